/* ncp_consts.vh */
`ifndef NCP_CONSTS_VH
`define NCP_CONSTS_VH

// Register addresses (7-bit)
`define NCP_ADDR_LOCK      7'h0a
`define NCP_ADDR_STATUS    7'h70
`define NCP_ADDR_STAGE0    7'h73
`define NCP_ADDR_STAGE1    7'h74
`define NCP_ADDR_CRC       7'h75
`define NCP_ADDR_IDENT     7'h7e

// Status field positions
`define NCP_ST_CNT_HI      7
`define NCP_ST_CNT_LO      2
`define NCP_ST_ECC         1
`define NCP_ST_READY       0

// Reset and preset values, counter saturation limit
`define NCP_LOCK_RST       8'h00
`define NCP_CRC_RST        8'h00
`define NCP_STAGE_RST      8'h00
`define NCP_CNT_MAX        6'h3f

// Checksum parameters
`define NCP_CRC_POLY       8'h2f
`define NCP_CRC_INIT       8'hff
`define NCP_CRC_XOR        8'hff

// Timing: programming time and restore delay in microseconds
`define NCP_PROG_US        1000
`define NCP_RESTORE_US     1000
`define NCP_CLK_MHZ        10
`define NCP_PROG_CYC       (`NCP_PROG_US * `NCP_CLK_MHZ)
`define NCP_RESTORE_CYC    (`NCP_RESTORE_US * `NCP_CLK_MHZ)

`endif

/* ncp_nv_config.v */
// Behaviour
// R1: Defaults change only in forced-normal mode with config bit and ready bit set.
// R2: Forced-normal mode keeps watchdog off, regulators on, transceiver active.
// R3: Host stages bytes at 73h and 74h, then writes matching CRC.
// R4: Matching CRC starts reprogramming; mismatch aborts, cells unchanged.
// R5: Successful reprogramming ends with a system reset.
// R6: Cells are not returned to reads while being reprogrammed.
// R7: After programming, ready bit reads 0 until factory presets restored.
// R8: Status at 70h: counter 7:2, ECC flag bit 1, ready bit 0.
// R9: Counter counts programs and restores, saturates at 111111, never blocks.
// R10: ECC flag set when single-bit failure is found and corrected.
// R11: Multi-bit failure means no restart after reprogramming.
// R12: CRC-8 poly 2Fh, init FFh, final XOR FFh, MSB first, 73h then 74h.
// R13: Read/write CRC confirm register at 75h, bits 7:0.
// R14: Restore needs reset pin low, CANH high, CANL low throughout delay.
// R15: After restore the device resets and enters forced-normal mode.
// R16: Receive data output held low throughout the restore.
// R17: Receive output goes high at restore end, low again in reset.
// R18: Read-only variant identification byte at 7Eh.
// R19: Locks block SPI writes only, never internal status updates.
// R20: Lock bits 6,5,4 protect 68h-6Fh, 50h-5Fh, 40h-4Fh; 1 blocks.
// R21: Lock bits 3,2,1,0 protect 30h-3Fh, 20h-2Fh, 10h-1Fh, 06h-09h.
// R22: Lock register lives at address 0Ah.
// R23: Frames carry 7-bit address then read flag, 0 means write.
// R24: CRC write outside forced-normal or ready condition never starts programming.
// R25: CRC check uses staging bytes held when CRC register is written.
`timescale 1ns/1ps
`default_nettype none
`include "ncp_consts.vh"

module ncp_nv_config #(
	parameter [7:0]  VARIANT_CODE = 8'h5a,   // Arbitrary value
	parameter [31:0] PROG_CYCLES  = `NCP_PROG_CYC,
	parameter [31:0] REST_CYCLES  = `NCP_RESTORE_CYC
) (
	// Clock and reset
	input  wire       mclk_in,
	input  wire       rst_b_in,
	// Register access from the SPI framer
	input  wire       reg_stb_in,
	input  wire [6:0] reg_addr_in,
	input  wire       reg_read_only_in,
	input  wire [7:0] reg_wdata_in,
	output reg  [7:0] reg_rdata_out,
	output reg        reg_wr_allow_out,
	// Mode and power-up inputs
	input  wire       factory_default_mode_cfg_in,
	input  wire       battery_powerup_in,
	input  wire       system_reset_pin_n_in,
	input  wire       canh_at_battery_in,
	input  wire       canl_at_ground_in,
	input  wire       power_on_flag_in,
	// Cell check results
	input  wire       ecc_single_fix_in,
	input  wire       ecc_multi_fail_in,
	// Outputs to the rest of the device
	output reg        forced_normal_out,
	output reg        watchdog_off_out,
	output reg        regulators_on_out,
	output reg        can_active_out,
	output reg        sys_reset_req_out,
	output reg        rxd_out,
	output reg        nv_busy_out,
	output reg  [6:0] lock_areas_out
);

	// States, one-hot
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_PROG = 4'b0010;
	localparam [3:0] ST_REST = 4'b0100;
	localparam [3:0] ST_HALT = 4'b1000;

	// Sequencer
	reg  [3:0]  state_reg;
	reg  [3:0]  state_next;
	reg  [31:0] timer_reg;
	reg  [31:0] timer_next;

	// Staging bytes and cells
	reg  [7:0]  stage0_reg;
	reg  [7:0]  stage1_reg;
	reg  [7:0]  cell0_reg;
	reg  [7:0]  cell1_reg;

	// Visible register contents; forced-normal and restore-spent flags are internal
	reg  [7:0]  nv_confirm_checksum_reg;
	reg  [6:0]  lock_reg;
	reg  [5:0]  nv_rewrite_counter_reg;
	reg         nv_corrected_error_flag_reg;
	reg         nv_program_ready_reg;
	reg         forced_normal_reg;
	reg         restore_spent_reg;

	// Combinational results
	reg  [7:0]  crc_calc;
	reg  [7:0]  rdata_next;
	reg         lock_hit;
	integer     i;

	wire is_wr = reg_stb_in & ~reg_read_only_in;
	wire [7:0] stage0_now = stage0_reg;
	wire [7:0] stage1_now = stage1_reg;
	wire restore_cond = ~system_reset_pin_n_in & canh_at_battery_in &
		canl_at_ground_in;
	// R14: only one restore per battery power-up window
	wire restore_go = battery_powerup_in & restore_cond &
		~restore_spent_reg;

	// R12: CRC-8 over staged bytes
	always @* begin
		crc_calc = `NCP_CRC_INIT ^ stage0_now;
		for (i = 0; i < 8; i = i + 1) begin
			if (crc_calc[7])
				crc_calc = {crc_calc[6:0], 1'b0} ^ `NCP_CRC_POLY;
			else
				crc_calc = {crc_calc[6:0], 1'b0};
		end
		crc_calc = crc_calc ^ stage1_now;
		for (i = 0; i < 8; i = i + 1) begin
			if (crc_calc[7])
				crc_calc = {crc_calc[6:0], 1'b0} ^ `NCP_CRC_POLY;
			else
				crc_calc = {crc_calc[6:0], 1'b0};
		end
		crc_calc = crc_calc ^ `NCP_CRC_XOR;
	end

	// R20: lock area decode for the address in flight
	always @* begin
		lock_hit = 1'b0;
		// R21: lower areas
		if (reg_addr_in >= 7'h06 && reg_addr_in <= 7'h09)
			lock_hit = lock_reg[0];
		else if (reg_addr_in[6:4] == 3'h1)
			lock_hit = lock_reg[1];
		else if (reg_addr_in[6:4] == 3'h2)
			lock_hit = lock_reg[2];
		else if (reg_addr_in[6:4] == 3'h3)
			lock_hit = lock_reg[3];
		else if (reg_addr_in[6:4] == 3'h4)
			lock_hit = lock_reg[4];
		else if (reg_addr_in[6:4] == 3'h5)
			lock_hit = lock_reg[5];
		else if (reg_addr_in[6:3] == 4'hd)
			lock_hit = lock_reg[6];
	end

	wire wr_ok = is_wr & ~lock_hit;
	// R24: confirm write stored in any mode; mode and ready gate only the start
	wire crc_wr = wr_ok & (reg_addr_in == `NCP_ADDR_CRC);
	// R1: forced-normal, config bit, ready bit
	wire prog_ok = forced_normal_reg & factory_default_mode_cfg_in &
		nv_program_ready_reg & state_reg[0];
	// R4: R25: compare against bytes held at the write
	wire start_prog = crc_wr & prog_ok & (reg_wdata_in == crc_calc);

	// Read data mux
	always @* begin
		case (reg_addr_in)
		`NCP_ADDR_LOCK:   rdata_next = {1'b0, lock_reg};
		// R8: status layout
		`NCP_ADDR_STATUS: rdata_next = {nv_rewrite_counter_reg,
			nv_corrected_error_flag_reg, nv_program_ready_reg};
		// R6: cells hidden while programming
		`NCP_ADDR_STAGE0: rdata_next = state_reg[1] ? 8'h00 : cell0_reg;
		`NCP_ADDR_STAGE1: rdata_next = state_reg[1] ? 8'h00 : cell1_reg;
		// R13: confirm register reads back
		`NCP_ADDR_CRC:    rdata_next = nv_confirm_checksum_reg;
		// R18: identification byte
		`NCP_ADDR_IDENT:  rdata_next = VARIANT_CODE;
		default:          rdata_next = 8'h00;
		endcase
	end

	// Sequencer next state
	always @* begin
		state_next = state_reg;
		timer_next = timer_reg;
		case (state_reg)
		ST_IDLE: begin
			if (restore_go) begin
				state_next = ST_REST;
				timer_next = REST_CYCLES - 32'h1;
			end else if (start_prog) begin
				state_next = ST_PROG;
				timer_next = PROG_CYCLES - 32'h1;
			end
		end
		ST_PROG: begin
			if (timer_reg != 32'h0)
				timer_next = timer_reg - 32'h1;
			// R11: no restart on multi-bit failure
			else if (ecc_multi_fail_in)
				state_next = ST_HALT;
			else
				state_next = ST_IDLE;
		end
		ST_REST: begin
			// R14: conditions must hold for the whole delay
			if (!restore_cond)
				state_next = ST_IDLE;
			else if (timer_reg != 32'h0)
				timer_next = timer_reg - 32'h1;
			else
				state_next = ST_IDLE;
		end
		ST_HALT: state_next = ST_HALT;
		default: state_next = ST_IDLE;
		endcase
	end

	wire prog_done = state_reg[1] & (timer_reg == 32'h0) & ~ecc_multi_fail_in;
	wire rest_done = state_reg[2] & (timer_reg == 32'h0) & restore_cond;

	// Sequencer state and timer
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg <= ST_IDLE;
			timer_reg <= 32'h0;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
		end
	end

	// Staging bytes, confirm value and lock bits
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			stage0_reg              <= `NCP_STAGE_RST;
			stage1_reg              <= `NCP_STAGE_RST;
			nv_confirm_checksum_reg <= `NCP_CRC_RST;
			lock_reg                <= 7'h00;
		end else begin
			// R3: R23: host writes with read flag clear
			if (wr_ok && reg_addr_in == `NCP_ADDR_STAGE0 && !state_reg[1])
				stage0_reg <= reg_wdata_in;
			if (wr_ok && reg_addr_in == `NCP_ADDR_STAGE1 && !state_reg[1])
				stage1_reg <= reg_wdata_in;
			// R13: confirm register store
			if (crc_wr)
				nv_confirm_checksum_reg <= reg_wdata_in;
			// R22: lock register, reserved bit dropped
			if (wr_ok && reg_addr_in == `NCP_ADDR_LOCK)
				lock_reg <= reg_wdata_in[6:0];
		end
	end

	// Non-volatile cells, read back through 73h and 74h
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cell0_reg <= `NCP_STAGE_RST;
			cell1_reg <= `NCP_STAGE_RST;
		end else if (start_prog) begin
			// R4: cells take the staged bytes only on a validated start
			cell0_reg <= stage0_reg;
			cell1_reg <= stage1_reg;
		end else if (rest_done) begin
			// R15: factory presets back in the cells
			cell0_reg <= `NCP_STAGE_RST;
			cell1_reg <= `NCP_STAGE_RST;
		end
	end

	// Status flags and restore bookkeeping
	// R19: internal updates, no lock check
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			nv_rewrite_counter_reg      <= 6'h00;
			nv_corrected_error_flag_reg <= 1'b0;
			nv_program_ready_reg        <= 1'b1;
			restore_spent_reg           <= 1'b0;
		end else begin
			// R9: saturating counter, never blocks
			if ((prog_done || rest_done) &&
				nv_rewrite_counter_reg != `NCP_CNT_MAX)
				nv_rewrite_counter_reg <= nv_rewrite_counter_reg + 6'h01;
			// R10: sticky corrected-error flag
			if (ecc_single_fix_in)
				nv_corrected_error_flag_reg <= 1'b1;
			// R7: protect after programming, restore re-arms
			if (prog_done)
				nv_program_ready_reg <= 1'b0;
			else if (rest_done)
				nv_program_ready_reg <= 1'b1;
			// R14: straps still held must not restart a restore
			if (rest_done)
				restore_spent_reg <= 1'b1;
			else if (!battery_powerup_in)
				restore_spent_reg <= 1'b0;
		end
	end

	// Mode and side-effect outputs
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			forced_normal_reg <= 1'b1;
			forced_normal_out <= 1'b1;
			watchdog_off_out  <= 1'b1;
			regulators_on_out <= 1'b1;
			can_active_out    <= 1'b1;
		end else begin
			// R15: restore returns to forced-normal mode
			if (rest_done)
				forced_normal_reg <= 1'b1;
			else
				forced_normal_reg <= factory_default_mode_cfg_in;
			// R2: forced-normal side effects
			forced_normal_out <= forced_normal_reg;
			watchdog_off_out  <= forced_normal_reg;
			regulators_on_out <= forced_normal_reg;
			can_active_out    <= forced_normal_reg;
		end
	end

	// Completion pulse, receive output and busy flag
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sys_reset_req_out <= 1'b0;
			rxd_out           <= 1'b1;
			nv_busy_out       <= 1'b0;
		end else begin
			// R5: reset pulse on completion
			sys_reset_req_out <= prog_done | rest_done;
			// R16: R17: receive output during restore and following reset
			if (state_next[2])
				rxd_out <= 1'b0;
			else if (rest_done)
				rxd_out <= 1'b1;
			else if (sys_reset_req_out && power_on_flag_in)
				rxd_out <= 1'b0;
			else
				rxd_out <= 1'b1;
			nv_busy_out <= state_next[1];
		end
	end

	// Register bus answers
	always @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reg_rdata_out    <= 8'h00;
			reg_wr_allow_out <= 1'b0;
			lock_areas_out   <= 7'h00;
		end else begin
			reg_rdata_out    <= rdata_next;
			reg_wr_allow_out <= wr_ok;
			lock_areas_out   <= lock_reg;
		end
	end

endmodule

`default_nettype wire

/* ncp_nv_config_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module ncp_nv_config_assertions #(
	parameter [7:0] VARIANT_CODE = 8'h5a
) (
	// Clock, reset, register access, mode and ECC inputs
	input wire logic       mclk_in,
	input wire logic       rst_b_in,
	input wire logic       reg_stb_in,
	input wire logic [6:0] reg_addr_in,
	input wire logic       reg_read_only_in,
	input wire logic       factory_default_mode_cfg_in,
	input wire logic       ecc_multi_fail_in,
	// Design outputs
	input wire logic [7:0] reg_rdata_out,
	input wire logic       reg_wr_allow_out,
	input wire logic       forced_normal_out,
	input wire logic       watchdog_off_out,
	input wire logic       regulators_on_out,
	input wire logic       can_active_out,
	input wire logic       sys_reset_req_out,
	input wire logic       nv_busy_out,
	input wire logic [6:0] lock_areas_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	// Address falls in a locked area
	function automatic logic lkd(input logic [6:0] a, input logic [6:0] l);
		lkd = (a[6:4] >= 3'h1 && a[6:4] <= 3'h5 && l[a[6:4]])
			|| (l[6] && a[6:3] == 4'hd) || (l[0] && a >= 7'h06 && a <= 7'h09);
	endfunction
	AST_LOCK_DENY: assert property (
		reg_stb_in && !reg_read_only_in && lkd(reg_addr_in, lock_areas_out)
		|=> !reg_wr_allow_out) else $error("locked write allowed");
	AST_LOCK_PASS: assert property (
		reg_stb_in && !reg_read_only_in && !lkd(reg_addr_in, lock_areas_out)
		&& reg_addr_in != 7'h70 && reg_addr_in != 7'h7e
		|=> reg_wr_allow_out) else $error("open write refused");
	AST_FN_OUTS: assert property (
		factory_default_mode_cfg_in |-> ##2 (forced_normal_out
		&& watchdog_off_out && regulators_on_out && can_active_out))
		else $error("forced-normal outputs wrong");
	AST_PULSE: assert property (
		sys_reset_req_out |=> !sys_reset_req_out) else $error("long pulse");
	AST_PROG_DONE: assert property (
		$rose(nv_busy_out) && !ecc_multi_fail_in |-> nv_busy_out[*6]
		##[1:6] sys_reset_req_out) else $error("no completion pulse");
	AST_NO_START: assert property (
		reg_stb_in && !reg_read_only_in && reg_addr_in == 7'h75
		&& !factory_default_mode_cfg_in && !nv_busy_out
		|-> ##1 !nv_busy_out ##1 !nv_busy_out) else $error("bad start");
	AST_STAGE_HIDE: assert property (
		$past(nv_busy_out) && (($past(reg_addr_in) == 7'h73)
		|| ($past(reg_addr_in) == 7'h74)) |-> reg_rdata_out == 8'h00)
		else $error("cells read while busy");
	AST_ID_READ: assert property (
		$past(reg_addr_in) == 7'h7e |-> reg_rdata_out == VARIANT_CODE)
		else $error("identification byte wrong");
	// Main scenarios reached
	cover property ($rose(nv_busy_out));
	cover property (sys_reset_req_out && !nv_busy_out);
	cover property (reg_stb_in && lkd(reg_addr_in, lock_areas_out));
endmodule
`default_nettype wire

/* ncp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ncp_host_model (
	// Clock and answers
	input  wire logic       mclk_in,
	input  wire logic [7:0] rdata_in,
	input  wire logic       allow_in,
	// Register access
	output var  logic       stb_out,
	output var  logic [6:0] addr_out,
	output var  logic       ro_out,
	output var  logic [7:0] wdata_out
);
	// Idle bus at start
	initial begin
		stb_out = 1'b0;
		addr_out = 7'h00;
		ro_out = 1'b1;
		wdata_out = 8'h00;
	end
	task automatic acc(input logic r, input logic [6:0] ad,
		input logic [7:0] d, output logic [7:0] q, output logic al);
		stb_out = 1'b1;
		ro_out = r;
		addr_out = ad;
		wdata_out = d;
		@(posedge mclk_in);
		#1;
		q = rdata_in;
		al = allow_in;
		stb_out = 1'b0;
		wdata_out = ~d;  // Released data no longer valid
		@(posedge mclk_in);
		#1;
	endtask
endmodule
`default_nettype wire

/* ncp_nv_config_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ncp_nv_config_tb;
	localparam [7:0] VC = 8'h3c;  // Arbitrary value
	logic        mclk_in, rst_b_in, stb, ro, al, seen, allow, cfg, bat;
	logic        pin_n, ch, cl, pof, sfix, mfail, fn, wd, rg, ca, srq;
	logic        rxd, busy, ecc, rdy;
	logic [6:0]  addr, lka;
	logic [7:0]  wdata, rdata, rd, a, c;
	logic [31:0] lfsr;
	int          err_count, comparisons, cyc, cnt;
	ncp_nv_config #(.VARIANT_CODE(VC), .PROG_CYCLES(32'd8),
		.REST_CYCLES(32'd8)) i_ncp_nv_config (.mclk_in(mclk_in),
		.rst_b_in(rst_b_in), .reg_stb_in(stb), .reg_addr_in(addr),
		.reg_read_only_in(ro), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.reg_wr_allow_out(allow), .factory_default_mode_cfg_in(cfg),
		.battery_powerup_in(bat), .system_reset_pin_n_in(pin_n),
		.canh_at_battery_in(ch), .canl_at_ground_in(cl),
		.power_on_flag_in(pof), .ecc_single_fix_in(sfix),
		.ecc_multi_fail_in(mfail), .forced_normal_out(fn),
		.watchdog_off_out(wd), .regulators_on_out(rg), .can_active_out(ca),
		.sys_reset_req_out(srq), .rxd_out(rxd), .nv_busy_out(busy),
		.lock_areas_out(lka));
	ncp_host_model i_ncp_host_model (.mclk_in(mclk_in), .rdata_in(rdata),
		.allow_in(allow), .stb_out(stb), .addr_out(addr), .ro_out(ro),
		.wdata_out(wdata));
	// Model helpers
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic blk(input logic [6:0] x, input logic [6:0] l);
		return (x[6:4] >= 3'h1 && x[6:4] <= 3'h5 && l[x[6:4]])
			|| (l[6] && x[6:3] == 4'hd) || (l[0] && x >= 7'h06 && x <= 7'h09);
	endfunction
	function automatic logic [7:0] crc8(input logic [15:0] d);
		logic [7:0] r;
		r = 8'hff;
		for (int k = 15; k >= 0; k--)
			r = {r[6:0], 1'b0} ^ ((r[7] ^ d[k]) ? 8'h2f : 8'h00);
		return r ^ 8'hff;
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [6:0] ad, input logic [7:0] d);
		i_ncp_host_model.acc(1'b0, ad, d, rd, al);
	endtask
	task automatic rdc(input logic [6:0] ad, input logic [7:0] e);
		i_ncp_host_model.acc(1'b1, ad, 8'h00, rd, al);
		chk(rd, e);
	endtask
	task automatic wait_pulse();
		seen = 1'b0;
		for (int k = 0; k < 30 && !seen; k++) begin
			@(posedge mclk_in);
			#1;
			seen = (srq === 1'b1);
		end
	endtask
	task automatic straps(input logic on);
		bat = on;
		pin_n = !on;
		ch = on;
		cl = on;
	endtask
	task automatic wrap_up();
		if (err_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Clock
	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end
	// Hang limit
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			wrap_up();
		end
	end
	// Main sequence
	initial begin
		rst_b_in = 1'b0;
		cfg = 1'b0;
		straps(1'b0);
		pof = 1'b1;
		sfix = 1'b0;
		mfail = 1'b0;
		lfsr = 32'ha2f3;
		ecc = 1'b0;
		rdy = 1'b1;
		repeat (8) @(posedge mclk_in);
		#1;
		rst_b_in = 1'b1;
		rdc(7'h70, 8'h01);
		wr(7'h7e, 8'h00);
		rdc(7'h7e, VC);
		rdc(7'h7f, 8'h00);
		wr(7'h0a, 8'hff);
		rdc(7'h0a, 8'h7f);
		chk({1'b0, lka}, 8'h7f);
		// Random locks against random write addresses
		repeat (40) begin
			lfsr = nxt(lfsr);
			wr(7'h0a, lfsr[15:8]);
			a = {1'b0, lfsr[6:0]};
			if (a >= 8'h70)
				a = a - 8'h10;
			wr(a[6:0], lfsr[23:16]);
			chk({7'h00, al}, {7'h00, !blk(a[6:0], lfsr[14:8])});
		end
		wr(7'h0a, 8'h00);
		c = crc8(lfsr[31:16]);
		wr(7'h73, lfsr[31:24]);
		wr(7'h74, lfsr[23:16]);
		wr(7'h75, c);
		chk({7'h00, busy}, 8'h00);
		cfg = 1'b1;
		wr(7'h75, c ^ 8'h01);
		chk({7'h00, busy}, 8'h00);
		rdc(7'h75, c ^ 8'h01);
		rdc(7'h73, 8'h00);
		wr(7'h75, c);
		chk({7'h00, busy}, 8'h01);
		rdc(7'h73, 8'h00);
		wait_pulse();
		chk({7'h00, seen}, 8'h01);
		rdc(7'h73, lfsr[31:24]);
		cnt = 1;
		rdy = 1'b0;
		rdc(7'h70, {6'(cnt), ecc, rdy});
		wr(7'h75, c);
		chk({7'h00, busy}, 8'h00);
		sfix = 1'b1;
		@(posedge mclk_in);
		#1;
		sfix = 1'b0;
		ecc = 1'b1;
		// Cut restore: straps drop early, nothing changes
		straps(1'b1);
		repeat (3) @(posedge mclk_in);
		#1;
		straps(1'b0);
		wait_pulse();
		chk({7'h00, seen}, 8'h00);
		rdc(7'h70, {6'(cnt), ecc, rdy});
		// Restores until the counter saturates
		repeat (63) begin
			straps(1'b1);
			repeat (4) @(posedge mclk_in);
			#1;
			chk({7'h00, rxd}, 8'h00);
			wait_pulse();
			chk({7'h00, seen}, 8'h01);
			chk({7'h00, rxd}, 8'h01);
			chk({4'h0, fn, wd, rg, ca}, 8'h0f);
			@(posedge mclk_in);
			#1;
			chk({7'h00, rxd}, 8'h00);
			straps(1'b0);
			cnt = (cnt < 63) ? cnt + 1 : 63;
			rdy = 1'b1;
			rdc(7'h70, {6'(cnt), ecc, rdy});
		end
		rdc(7'h74, 8'h00);
		mfail = 1'b1;
		wr(7'h75, c);
		chk({7'h00, busy}, 8'h01);
		wait_pulse();
		chk({7'h00, seen}, 8'h00);
		wrap_up();
	end
endmodule
bind ncp_nv_config ncp_nv_config_assertions #(.VARIANT_CODE(VARIANT_CODE))
	i_ncp_nv_config_assertions (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
	.reg_stb_in(reg_stb_in), .reg_addr_in(reg_addr_in),
	.reg_read_only_in(reg_read_only_in), .reg_rdata_out(reg_rdata_out),
	.factory_default_mode_cfg_in(factory_default_mode_cfg_in),
	.ecc_multi_fail_in(ecc_multi_fail_in), .nv_busy_out(nv_busy_out),
	.reg_wr_allow_out(reg_wr_allow_out), .forced_normal_out(forced_normal_out),
	.watchdog_off_out(watchdog_off_out), .can_active_out(can_active_out),
	.regulators_on_out(regulators_on_out), .lock_areas_out(lock_areas_out),
	.sys_reset_req_out(sys_reset_req_out));
`default_nettype wire
